// *** sslrca_crc.sv ***
// crc-16 accumulator shared by receive check and response generation
`timescale 1ns/1ps
module sslrca_crc (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        init,
  input  wire logic        en,
  input  wire logic [7:0]  din,
  output logic      [15:0] crc
);
  logic [15:0] crc_ff;
  logic [15:0] base;

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ sslrca_pkg::CRC_POLY) : (r >> 1); // [R20]
    end
    return r;
  endfunction

  assign base = init ? sslrca_pkg::CRC_INIT : crc_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crc_ff <= sslrca_pkg::CRC_INIT;
    end else begin
      crc_ff <= en ? crc_upd(base, din) : base;
    end
  end
  assign crc = crc_ff;
endmodule

// *** sslrca_fifo.sv ***
// response byte fifo with valid and ready on both sides
`timescale 1ns/1ps
module sslrca_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_ff;
  logic [AW:0]  rd_ff;
  logic         full;
  logic         empty;

  assign empty     = (wr_ff == rd_ff);
  assign full      = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ff[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wr_ff[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ff <= '0;
    end else if (in_valid && !full) begin
      wr_ff <= wr_ff + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_ff <= '0;
    end else if (out_ready && !empty) begin
      rd_ff <= rd_ff + 1'b1;
    end
  end
endmodule

// *** sslrca_master.sv ***
// master model on the serial link: sends queries, collects replies
`timescale 1ns/1ps
module sslrca_master (
  input  wire logic       clk,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data
);
  // ****************************************
  // link master
  // ****************************************
  logic [7:0]  got[$];
  logic [15:0] lfsr = 16'hACE1;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end
  // slow consumer: stalls the reply stream at random
  always @(negedge clk) begin
    lfsr     <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    tx_ready <= lfsr[0] | lfsr[3];
  end
  always @(posedge clk) if (tx_valid && tx_ready) got.push_back(tx_data);
  // reads never go to the broadcast address
  // next query only after the reply plus silence
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data  = b[i];
    end
    @(negedge clk);
    rx_valid = 1'b0;
    // released line no longer shows the last byte
    rx_data  = ~rx_data;
  endtask
endmodule

// *** sslrca_pkg.sv ***
// constants, states and response kinds of the serial slave command block
package sslrca_pkg;
  // ****************************************
  // function and exception codes
  // ****************************************
  localparam logic [7:0]  FC_READ      = 8'h03;
  localparam logic [7:0]  FC_COIL      = 8'h05;
  localparam logic [7:0]  FC_REG       = 8'h06;
  localparam logic [7:0]  FC_EXC_FLAG  = 8'h80;
  localparam logic [7:0]  EXC_FUNC     = 8'h01;
  localparam logic [7:0]  EXC_ADDR     = 8'h02;
  localparam logic [7:0]  EXC_DATA     = 8'h03;
  localparam logic [7:0]  EXC_RANGE    = 8'h21;
  localparam logic [7:0]  EXC_STATE    = 8'h22;
  localparam logic [7:0]  BCAST_ADDR   = 8'h00;
  localparam logic [7:0]  RUN_SRC_LINK = 8'h03;
  // ****************************************
  // coils, registers and values
  // ****************************************
  localparam logic [15:0] COIL_ON        = 16'hFF00;
  localparam logic [15:0] COIL_OFF       = 16'h0000;
  localparam logic [15:0] RUN_COIL       = 16'h0001;
  localparam logic [15:0] REG_TRIP_CAUSE = 16'h0012;
  localparam logic [15:0] REG_TRIP_STATE = 16'h0013;
  localparam logic [15:0] REG_BASE_FREQ  = 16'h1203;
  localparam logic [15:0] BASE_FREQ_RST  = 16'h0032;
  localparam logic [15:0] BASE_FREQ_MIN  = 16'h001E;
  localparam logic [15:0] BASE_FREQ_MAX  = 16'h0190;
  localparam logic [15:0] MAX_READ_REGS  = 16'h0008;
  localparam logic [15:0] CRC_POLY       = 16'hA001;
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [3:0]  QUERY_LEN      = 4'h8;
  localparam logic [3:0]  CRC_FROM       = 4'h6;
  localparam logic [4:0]  BODY_ECHO      = 5'h06;
  localparam logic [4:0]  BODY_EXC       = 5'h03;
  localparam logic [4:0]  READ_HDR       = 5'h03;
  // ****************************************
  // timing
  // ****************************************
  localparam longint CLK_HZ        = 50000000;
  localparam longint CLK_PERIOD_NS = 20;
  localparam longint BAUD_BPS      = 9600;
  localparam longint CHAR_BITS     = 11;
  localparam longint SILENCE_HALF  = 7;
  localparam longint MS_NS         = 1000000;
  localparam longint SILENCE_CYC_L = (CLK_HZ * CHAR_BITS * SILENCE_HALF + 2 * BAUD_BPS - 1) / (2 * BAUD_BPS);
  localparam int     SILENCE_CYC   = int'(SILENCE_CYC_L);
  localparam int     MS_CYC        = int'(MS_NS / CLK_PERIOD_NS);
  localparam int     FIFO_W        = 8;
  localparam int     FIFO_D        = 8;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_EXEC = 3'b010,
    ST_WAIT = 3'b011,
    ST_SEND = 3'b100
  } sslrca_state_t;
  typedef enum logic [1:0] {
    K_ECHO = 2'b00,
    K_READ = 2'b01,
    K_EXC  = 2'b10
  } sslrca_kind_t;
endpackage

// *** sslrca_tb_top.sv ***
// self-checking bench for the serial slave command block
`timescale 1ns/1ps
module sslrca_tb_top;
  // ****************************************
  // bench
  // ****************************************
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  own_addr = 8'h05;
  logic        rx_valid, tx_valid, tx_ready, run_coil, run_command;
  logic        drive_running = 1'b0;
  logic        rx_err = 1'b0;
  logic [15:0] rwait = 16'h0001;
  logic [7:0]  rx_data, tx_data;
  logic [7:0]  run_src = 8'h03;
  logic [15:0] cause = 16'h0007;
  logic [15:0] dstate = 16'h0002;
  logic [15:0] base_freq;
  logic [31:0] seed = 32'h637C;
  logic [7:0]  none[$];
  int          err_total = 0;
  int          checks_done = 0;
  always #10 clk = ~clk;
  sslrca_master i_mst (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data));
  sslrca_top #(.SILENCE_CYCLES(20), .MS_CYCLES(5)) i_dut (.clk(clk), .resetn(resetn),
    .own_addr(own_addr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .trip_history_monitor_cause(cause),
    .trip_history_monitor_state(dstate), .run_command_source_param(run_src),
    .reply_wait_time_param(rwait), .drive_running(drive_running), .base_frequency_param(base_freq),
    .run_coil(run_coil), .run_command(run_command));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // crc goes out low half first, as on the wire
  function automatic void addcrc(inout logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i]) begin
      c ^= {8'h00, f[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
  endfunction
  function automatic void mk(output logic [7:0] f[$], input logic [7:0] a, fc, input logic [15:0] n, v);
    f = {a, fc, n[15:8], n[7:0], v[15:8], v[7:0]};
    addcrc(f);
  endfunction
  task automatic chk(input logic [15:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: %s got %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic xact(input logic [7:0] q[$], r[$]);
    int n;
    i_mst.got.delete();
    i_mst.send(q);
    n = 0;
    while (i_mst.got.size() < r.size() && n < 400) begin
      @(posedge clk);
      n++;
    end
    repeat (60) @(posedge clk);
    chk(16'(i_mst.got.size()), 16'(r.size()), "reply length");
    foreach (r[i]) if (i < i_mst.got.size()) chk(i_mst.got[i], r[i], "reply byte");
    @(negedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #(40000 * 20);
    err_total++;
    finish_test();
  end
  initial begin
    logic [7:0]  q[$];
    logic [7:0]  r[$];
    logic [15:0] v;
    logic [31:0] w;
    logic [47:0] ex[6];
    ex = '{48'h07_0000_0000_01, 48'h03_2000_0001_02, 48'h03_0011_0009_03, 48'h05_0000_1234_03,
           48'h06_1202_0191_21, 48'h06_0011_0005_22};
    w = rnd();
    own_addr = w[7:0] | 8'h01;
    cause = w[31:16];
    dstate = w[15:0];
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    chk(base_freq, 16'h0032, "freq reset");
    for (int i = 0; i < 3; i++) begin
      w = rnd();
      rwait = 16'(w[25:24]);
      v = (i == 0) ? 16'h001E : (i == 1) ? 16'h0190 : 16'h001E + 16'(w % 371);
      mk(q, own_addr, 8'h06, 16'h1202, v);
      xact(q, q);
      chk(base_freq, v, "freq write");
      mk(q, own_addr, 8'h03, 16'h1202, 16'h0001);
      r = {own_addr, 8'h03, 8'h02, v[15:8], v[7:0]};
      addcrc(r);
      xact(q, r);
    end
    mk(q, own_addr, 8'h03, 16'h0011, 16'h0002);
    r = {own_addr, 8'h03, 8'h04, cause[15:8], cause[7:0], dstate[15:8], dstate[7:0]};
    addcrc(r);
    xact(q, r);
    mk(q, own_addr, 8'h05, 16'h0000, 16'hFF00);
    xact(q, q);
    chk(run_coil, 1'b1, "coil on");
    chk(run_command, 1'b1, "run on");
    run_src = 8'h01;
    repeat (3) @(negedge clk);
    chk(run_command, 1'b0, "run gated");
    mk(q, 8'h00, 8'h05, 16'h0000, 16'h0000);
    xact(q, none);
    chk(run_coil, 1'b0, "coil off");
    mk(q, own_addr, 8'h06, 16'h1202, 16'h0040);
    q[7] = ~q[7];
    xact(q, none);
    mk(q, own_addr ^ 8'h80, 8'h06, 16'h1202, 16'h0040);
    xact(q, none);
    rx_err = 1'b1;
    mk(q, own_addr, 8'h06, 16'h1202, 16'h0040);
    xact(q, none);
    rx_err = 1'b0;
    mk(q, own_addr, 8'h06, 16'h1202, 16'h0040);
    void'(q.pop_back());
    xact(q, none);
    chk(base_freq, v, "freq kept");
    foreach (ex[i]) begin
      mk(q, own_addr, ex[i][47:40], ex[i][39:24], ex[i][23:8]);
      r = {own_addr, ex[i][47:40] | 8'h80, ex[i][7:0]};
      addcrc(r);
      xact(q, r);
    end
    drive_running = 1'b1;
    mk(q, own_addr, 8'h06, 16'h1202, 16'h0050);
    r = {own_addr, 8'h86, 8'h22};
    addcrc(r);
    xact(q, r);
    finish_test();
  end
endmodule

// *** sslrca_top.sv ***
// slave command interpreter: read registers, write coil, write register
`timescale 1ns/1ps
// Contract
// [R01] read query: addr, 03, start, count, crc
// [R02] byte count equals two per register
// [R03] registers ascending, upper byte first
// [R04] master never broadcasts a read
// [R05] target number is query number plus one
// [R06] FF00h switches coil on, 0000h off
// [R07] coil write: addr, 05, coil, value, crc
// [R08] register write: addr, 06, reg, data, crc
// [R09] broadcast writes execute without response
// [R10] successful write echoes the query
// [R11] failed operation gives exception response
// [R12] crc last, upper byte first; the code sends the low byte first
// [R13] trip cause 0012h, trip state 0013h
// [R14] base frequency at 1203h, 1 Hz
// [R15] coil 1 runs only when source 03
// [R16] exception: addr, function plus 80h, code, crc
// [R17] exception codes 01h 02h 03h 21h 22h
// [R18] reply after silence plus reply wait
// [R19] ignore foreign address, errors, bad length
// [R20] crc-16 poly A001h, init FFFFh
// [R21] bad crc frame discarded silently
module sslrca_top #(
  parameter int SILENCE_CYCLES = sslrca_pkg::SILENCE_CYC,
  parameter int MS_CYCLES      = sslrca_pkg::MS_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  own_addr,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_err,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic      [7:0]  tx_data,
  input  wire logic [15:0] trip_history_monitor_cause,
  input  wire logic [15:0] trip_history_monitor_state,
  input  wire logic [7:0]  run_command_source_param,
  input  wire logic [15:0] reply_wait_time_param,
  input  wire logic        drive_running,
  output logic      [15:0] base_frequency_param,
  output logic             run_coil,
  output logic             run_command
);
  // ****************************************
  // declarations
  // ****************************************
  sslrca_pkg::sslrca_state_t state_ff;
  sslrca_pkg::sslrca_state_t nxt_state;
  sslrca_pkg::sslrca_kind_t  kind_ff;
  sslrca_pkg::sslrca_kind_t  nxt_kind;
  logic [7:0]  buf_ff [8];
  logic [3:0]  cnt_ff;
  logic        err_ff;
  logic [31:0] gap_ff;
  logic [15:0] ms_ff;
  logic [4:0]  idx_ff;
  logic [7:0]  exc_ff;
  logic [7:0]  nxt_exc;
  logic [3:0]  rcnt_ff;
  logic [15:0] base_ff;
  logic        coil_ff;
  logic        run_ff;
  logic        tx_valid_ff;
  logic [7:0]  tx_data_ff;
  logic [15:0] num;
  logic [15:0] val;
  logic [15:0] tgt;
  logic [15:0] crc_q;
  logic        crc_ok;
  logic        frame_ok;
  logic        bcast;
  logic        respond;
  logic        wr_coil;
  logic        wr_base;
  logic        frame_end;
  logic        wait_done;
  logic [4:0]  blen;
  logic        push_v;
  logic [7:0]  push_d;
  logic        in_ready;
  logic        crc_init;
  logic        crc_en;
  logic [7:0]  crc_din;
  logic        f_valid;
  logic [7:0]  f_data;
  logic        f_ready;
  logic [4:0]  off;
  logic [15:0] rv;

  function automatic logic reg_mapped(input logic [15:0] a);
    return (a == sslrca_pkg::REG_TRIP_CAUSE) || (a == sslrca_pkg::REG_TRIP_STATE) ||
           (a == sslrca_pkg::REG_BASE_FREQ);
  endfunction

  function automatic logic [15:0] reg_val(input logic [15:0] a, input logic [15:0] tc, input logic [15:0] ts,
                                          input logic [15:0] bf);
    case (a)
      sslrca_pkg::REG_TRIP_CAUSE: reg_val = tc; // [R13]
      sslrca_pkg::REG_TRIP_STATE: reg_val = ts; // [R13]
      sslrca_pkg::REG_BASE_FREQ:  reg_val = bf; // [R14]
      default:                    reg_val = 16'h0000;
    endcase
  endfunction

  // ****************************************
  // query fields and validity
  // ****************************************
  assign num      = {buf_ff[2], buf_ff[3]};                 // [R01] [R07] [R08]
  assign val      = {buf_ff[4], buf_ff[5]};                 // [R07] [R08]
  assign tgt      = num + 16'h0001;                         // [R05]
  // the byte sent first on the line is the low half of the reflected crc register
  assign crc_ok   = (crc_q == {buf_ff[7], buf_ff[6]});      // [R12] [R21]
  assign bcast    = (buf_ff[0] == sslrca_pkg::BCAST_ADDR);
  // foreign address, reception error or wrong length drop the frame
  assign frame_ok = (cnt_ff == sslrca_pkg::QUERY_LEN) && !err_ff && crc_ok &&
                    ((buf_ff[0] == own_addr) || bcast);     // [R19] [R21]
  assign frame_end = (state_ff == sslrca_pkg::ST_RX) && !rx_valid && (gap_ff == 32'(SILENCE_CYCLES - 1));
  assign wait_done = (state_ff == sslrca_pkg::ST_WAIT) && (ms_ff == reply_wait_time_param);

  // ****************************************
  // execution decode
  // ****************************************
  always_comb begin
    nxt_kind = sslrca_pkg::K_ECHO;
    nxt_exc  = 8'h00;
    wr_coil  = 1'b0;
    wr_base  = 1'b0;
    case (buf_ff[1])
      sslrca_pkg::FC_READ: begin
        if ((val == 16'h0000) || (val > sslrca_pkg::MAX_READ_REGS)) begin
          nxt_kind = sslrca_pkg::K_EXC;
          nxt_exc  = sslrca_pkg::EXC_DATA;                  // [R17]
        end else if (!reg_mapped(tgt)) begin
          nxt_kind = sslrca_pkg::K_EXC;
          nxt_exc  = sslrca_pkg::EXC_ADDR;                  // [R17]
        end else begin
          nxt_kind = sslrca_pkg::K_READ;                    // [R01]
        end
      end
      sslrca_pkg::FC_COIL: begin
        if (tgt != sslrca_pkg::RUN_COIL) begin
          nxt_kind = sslrca_pkg::K_EXC;
          nxt_exc  = sslrca_pkg::EXC_ADDR;
        end else if ((val != sslrca_pkg::COIL_ON) && (val != sslrca_pkg::COIL_OFF)) begin
          nxt_kind = sslrca_pkg::K_EXC;
          nxt_exc  = sslrca_pkg::EXC_DATA;                  // [R06]
        end else begin
          wr_coil = frame_ok;                               // [R07]
        end
      end
      sslrca_pkg::FC_REG: begin
        if (tgt == sslrca_pkg::REG_BASE_FREQ) begin
          if ((val < sslrca_pkg::BASE_FREQ_MIN) || (val > sslrca_pkg::BASE_FREQ_MAX)) begin
            nxt_kind = sslrca_pkg::K_EXC;
            nxt_exc  = sslrca_pkg::EXC_RANGE;               // [R17]
          end else if (drive_running) begin
            nxt_kind = sslrca_pkg::K_EXC;
            nxt_exc  = sslrca_pkg::EXC_STATE;               // [R17]
          end else begin
            wr_base = frame_ok;                             // [R08]
          end
        end else if (reg_mapped(tgt)) begin
          nxt_kind = sslrca_pkg::K_EXC;
          nxt_exc  = sslrca_pkg::EXC_STATE;                 // read-only target
        end else begin
          nxt_kind = sslrca_pkg::K_EXC;
          nxt_exc  = sslrca_pkg::EXC_ADDR;
        end
      end
      default: begin
        nxt_kind = sslrca_pkg::K_EXC;
        nxt_exc  = sslrca_pkg::EXC_FUNC;                    // [R11] [R17]
      end
    endcase
    if (state_ff != sslrca_pkg::ST_EXEC) begin
      wr_coil = 1'b0;
      wr_base = 1'b0;
    end
  end
  // broadcast reads are never answered either
  assign respond = frame_ok && !bcast;                      // [R04] [R09]

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sslrca_pkg::ST_IDLE: if (rx_valid) nxt_state = sslrca_pkg::ST_RX;
      sslrca_pkg::ST_RX:   if (frame_end) nxt_state = sslrca_pkg::ST_EXEC;
      sslrca_pkg::ST_EXEC: nxt_state = respond ? sslrca_pkg::ST_WAIT : sslrca_pkg::ST_IDLE;
      sslrca_pkg::ST_WAIT: if (wait_done) nxt_state = sslrca_pkg::ST_SEND; // [R18]
      sslrca_pkg::ST_SEND: if (in_ready && (idx_ff == blen + 5'h01)) nxt_state = sslrca_pkg::ST_IDLE;
      default:             nxt_state = sslrca_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= sslrca_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      kind_ff <= sslrca_pkg::K_ECHO;
      exc_ff  <= 8'h00;
      rcnt_ff <= 4'h0;
    end else if (state_ff == sslrca_pkg::ST_EXEC) begin
      kind_ff <= nxt_kind;
      exc_ff  <= nxt_exc;
      rcnt_ff <= val[3:0];
    end
  end

  // ****************************************
  // receive buffer and framing
  // ****************************************
  always_ff @(posedge clk) begin
    if (((state_ff == sslrca_pkg::ST_IDLE) || (state_ff == sslrca_pkg::ST_RX)) && rx_valid &&
        (cnt_ff < sslrca_pkg::QUERY_LEN || state_ff == sslrca_pkg::ST_IDLE)) begin
      buf_ff[(state_ff == sslrca_pkg::ST_IDLE) ? 3'h0 : cnt_ff[2:0]] <= rx_data;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 4'h0;
      err_ff <= 1'b0;
    end else if (state_ff == sslrca_pkg::ST_IDLE && rx_valid) begin
      cnt_ff <= 4'h1;
      err_ff <= rx_err;
    end else if (state_ff == sslrca_pkg::ST_RX) begin
      if (rx_valid && cnt_ff != 4'hF) cnt_ff <= cnt_ff + 4'h1; // overlong frames saturate
      if (rx_err) err_ff <= 1'b1;
    end
  end
  // gap counts line silence while receiving, then cycles of each reply-wait millisecond
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap_ff <= 32'h00000000;
      ms_ff  <= 16'h0000;
    end else if (state_ff == sslrca_pkg::ST_RX) begin
      gap_ff <= rx_valid ? 32'h00000000 : gap_ff + 32'h00000001;
      ms_ff  <= 16'h0000;
    end else if (state_ff == sslrca_pkg::ST_WAIT && !wait_done) begin
      if (gap_ff >= 32'(MS_CYCLES - 1)) begin
        gap_ff <= 32'h00000000;
        ms_ff  <= ms_ff + 16'h0001;
      end else begin
        gap_ff <= gap_ff + 32'h00000001;
      end
    end else begin
      gap_ff <= 32'h00000000;
      ms_ff  <= 16'h0000;
    end
  end

  // ****************************************
  // controlled state
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      coil_ff <= 1'b0;
    end else if (wr_coil) begin
      coil_ff <= (val == sslrca_pkg::COIL_ON);              // [R06]
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      base_ff <= sslrca_pkg::BASE_FREQ_RST;
    end else if (wr_base) begin
      base_ff <= val;                                       // [R14]
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_ff <= 1'b0;
    end else begin
      run_ff <= coil_ff && (run_command_source_param == sslrca_pkg::RUN_SRC_LINK); // [R15]
    end
  end

  // ****************************************
  // response generation
  // ****************************************
  always_comb begin
    case (kind_ff)
      sslrca_pkg::K_READ: blen = sslrca_pkg::READ_HDR + {rcnt_ff, 1'b0};
      sslrca_pkg::K_EXC:  blen = sslrca_pkg::BODY_EXC;
      default:            blen = sslrca_pkg::BODY_ECHO;
    endcase
  end
  assign off = idx_ff - sslrca_pkg::READ_HDR;
  assign rv  = reg_val(tgt + {12'h000, off[4:1]}, trip_history_monitor_cause, trip_history_monitor_state,
                       base_ff);                            // [R03]
  always_comb begin
    push_d = 8'h00;
    if (idx_ff == blen) begin
      push_d = crc_q[7:0];                                  // [R12]
    end else if (idx_ff > blen) begin
      push_d = crc_q[15:8];
    end else begin
      case (kind_ff)
        sslrca_pkg::K_READ: begin
          if (idx_ff == 5'h00)      push_d = buf_ff[0];
          else if (idx_ff == 5'h01) push_d = buf_ff[1];
          else if (idx_ff == 5'h02) push_d = {3'h0, rcnt_ff, 1'b0}; // [R02]
          else                      push_d = off[0] ? rv[7:0] : rv[15:8]; // [R03]
        end
        sslrca_pkg::K_EXC: begin
          if (idx_ff == 5'h00)      push_d = buf_ff[0];
          else if (idx_ff == 5'h01) push_d = buf_ff[1] | sslrca_pkg::FC_EXC_FLAG; // [R16]
          else                      push_d = exc_ff;
        end
        default: push_d = buf_ff[idx_ff[2:0]];             // [R10]
      endcase
    end
  end
  assign push_v = (state_ff == sslrca_pkg::ST_SEND);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idx_ff <= 5'h00;
    end else if (!push_v) begin
      idx_ff <= 5'h00;
    end else if (in_ready) begin
      idx_ff <= idx_ff + 5'h01;                             // fifo stall holds the byte
    end
  end

  // rebuilding the echo crc equals the query crc, already checked
  assign crc_init = (state_ff == sslrca_pkg::ST_IDLE) || wait_done;
  assign crc_en   = ((state_ff == sslrca_pkg::ST_IDLE || state_ff == sslrca_pkg::ST_RX) && rx_valid &&
                     (state_ff == sslrca_pkg::ST_IDLE || cnt_ff < sslrca_pkg::CRC_FROM)) ||
                    (push_v && in_ready && idx_ff < blen);
  assign crc_din  = push_v ? push_d : rx_data;
  sslrca_crc u_crc (
    .clk    (clk),
    .resetn (resetn),
    .init   (crc_init),
    .en     (crc_en),
    .din    (crc_din),
    .crc    (crc_q)
  );                                                        // [R20]

  sslrca_fifo #(
    .W (sslrca_pkg::FIFO_W),
    .D (sslrca_pkg::FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (push_v),
    .in_ready  (in_ready),
    .in_data   (push_d),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );
  assign f_ready = !tx_valid_ff || tx_ready;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_valid_ff <= 1'b0;
      tx_data_ff  <= 8'h00;
    end else if (f_ready) begin
      tx_valid_ff <= f_valid;
      tx_data_ff  <= f_data;
    end
  end

  assign tx_valid             = tx_valid_ff;
  assign tx_data              = tx_data_ff;
  assign base_frequency_param = base_ff;
  assign run_coil             = coil_ff;
  assign run_command          = run_ff;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_exec_bad;
    state_ff == sslrca_pkg::ST_EXEC && !crc_ok;
  endsequence
  sequence s_crc_first;
    push_v && in_ready && idx_ff == blen;
  endsequence
  a_crc_discard: assert property (s_exec_bad |-> !wr_coil && !wr_base ##1 state_ff == sslrca_pkg::ST_IDLE)
    else $error("bad crc frame not discarded"); // [R21]
  a_bcast_quiet: assert property (state_ff == sslrca_pkg::ST_EXEC && bcast |=> state_ff == sslrca_pkg::ST_IDLE)
    else $error("broadcast got a response"); // [R09]
  a_exc_func: assert property (push_v && kind_ff == sslrca_pkg::K_EXC && idx_ff == 5'h01 |->
    push_d == (buf_ff[1] | 8'h80))
    else $error("exception function code wrong"); // [R16]
  a_byte_count: assert property (push_v && kind_ff == sslrca_pkg::K_READ && idx_ff == 5'h02 |->
    push_d == {buf_ff[5][6:0], 1'b0})
    else $error("byte count wrong"); // [R02]
  a_crc_order: assert property (s_crc_first |-> push_d == crc_q[7:0] ##1 push_v && push_d == $past(crc_q[15:8]))
    else $error("crc byte order wrong"); // [R12]
  a_coil_on: assert property (wr_coil |=> coil_ff == ($past(val) == 16'hFF00))
    else $error("coil value not applied"); // [R06]
  a_run_gate: assert property (run_command |-> $past(coil_ff) && $past(run_command_source_param) == 8'h03)
    else $error("run without link source"); // [R15]
  a_base_write: assert property (wr_base |=> base_frequency_param == $past(val))
    else $error("base frequency not written"); // [R14]
  a_reply_wait: assert property (state_ff == sslrca_pkg::ST_SEND && $past(state_ff) == sslrca_pkg::ST_WAIT |->
    $past(ms_ff) == $past(reply_wait_time_param))
    else $error("reply sent before wait"); // [R18]
endmodule
